// ===== src/omw_top.sv
// oscillator mode and wake-up control with an Avalon-MM register slave
// Operation
// - fast enable rising clears fast stable flag; flag sets after settling
// - fast control bit 0 enables fast crystal, reset 0
// - slow enable rising clears slow stable flag; flag sets after settling
// - slow control bit 0 enables slow crystal, reset 0
// - slow control bit 2 selects quick start or low-power start
// - speed-up bit frozen while slow crystal is system clock
// - clock select 111 switches system clock to low-speed clock
// - slow clock from crystal or RC; switch waits for stable source
// - clock select 000..110 returns to fast clock divided 1..64
// - halt picks sleep or idle mode from the two hold bits
// - sleep stops all clocks except watchdog; CPU stops at halt
// - idle modes keep slow, both, or fast clocks; CPU halted
// - power-down entry sets power-down flag, clears time-out flag
// - power-down entry clears watchdog counter, counting continues
// - wake on port A falling edge, interrupt or watchdog overflow
// - power-down flag set by halt, cleared by power-up or watchdog clear
// - watchdog overflow while down sets time-out, resets only pc and sp
// - per-pin wake enable; pin wake resumes after halt
// - disabled interrupt or full stack resumes after halt, stays pending
// - enabled interrupt with stack room takes normal interrupt response
// - interrupts pending before power-down cannot wake the device
// - low clock source bit: 0 internal RC, 1 slow crystal
// - internal RC stays on while watchdog enabled
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "omw_defines.svh"
module omw_top
    import omw_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int NUM_IRQ = 8,
    parameter int FAST_SETTLE_CYC = `OMW_FAST_SETTLE_CYC,
    parameter int SLOW_FAST_CYC = `OMW_SLOW_FAST_CYC,
    parameter int SLOW_LOWP_CYC = `OMW_SLOW_LOWP_CYC
)(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic [1:0] AVS_RESPONSE_O,
    input wire omw_core_t CORE_I,
    input wire logic [NUM_IRQ-1:0] IRQ_FLAG_I,
    input wire logic [NUM_IRQ-1:0] IRQ_ENABLE_I,
    input wire logic [NUM_PINS-1:0] PORT_A_I,
    output omw_cpu_t CPU_O,
    output logic FAST_OSC_EN_O,
    output logic SLOW_OSC_EN_O,
    output logic SLOW_OSC_SPEEDUP_O,
    output logic LOW_RC_EN_O,
    output logic SYS_CLK_SLOW_O,
    output logic SYS_CLK_EN_O,
    output logic FAST_CLK_RUN_O,
    output logic LOW_CLK_RUN_O,
    output omw_pmode_t POWER_MODE_O
);
    localparam int FW = $clog2(FAST_SETTLE_CYC + 1);
    localparam int SW = $clog2(SLOW_LOWP_CYC + 1);

    logic [7:0] mode_ctrl;
    logic fast_en, slow_en, speedup, wdt_en;
    logic fast_stable, slow_stable, power_down_flag, to_flag;
    logic [NUM_PINS-1:0] wake_en;
    logic [FW-1:0] fast_cnt;
    logic [SW-1:0] slow_cnt;
    logic [NUM_PINS-1:0] pin_s1, pin_s2, pin_s3;
    logic [NUM_IRQ-1:0] irq_mask;
    logic clk_slow;
    logic [5:0] div_cnt;
    logic wait_stable;
    logic rd_pend;
    logic [31:0] rdata;
    omw_pmode_t pmode;
    omw_cpu_t cpu;

    // bus decode
    wire wr = AVS_WRITE_I && AVS_BYTEENABLE_I[0];
    wire wr_mode = wr && AVS_ADDRESS_I == `OMW_OFF_MODE_CTRL;
    wire wr_fast = wr && AVS_ADDRESS_I == `OMW_OFF_FAST_CTRL;
    wire wr_slow = wr && AVS_ADDRESS_I == `OMW_OFF_SLOW_CTRL;
    wire wr_wake = wr && AVS_ADDRESS_I == `OMW_OFF_WAKE_EN;
    wire wr_misc = wr && AVS_ADDRESS_I == `OMW_OFF_MISC;
    wire [7:0] wd = AVS_WRITEDATA_I[7:0];
    wire mapped = AVS_ADDRESS_I <= `OMW_OFF_MISC;

    wire [2:0] cks = mode_ctrl[`OMW_CKS_LSB +: 3];
    wire low_clock_source_select = mode_ctrl[`OMW_BIT_FSS];
    wire hold_fast = mode_ctrl[`OMW_BIT_FAST_OSC_HOLD_IN_HALT];
    wire hold_slow = mode_ctrl[`OMW_BIT_SLOW_OSC_HOLD_IN_HALT];
    wire want_slow = cks == `OMW_CKS_SLOW;
    wire slow_xtal_is_sys = clk_slow && low_clock_source_select;
    wire low_src_stable = low_clock_source_select ? slow_stable : 1'b1;
    wire [FW-1:0] fast_target = FW'(FAST_SETTLE_CYC);
    wire [SW-1:0] slow_target = speedup ? SW'(SLOW_FAST_CYC) : SW'(SLOW_LOWP_CYC);
    wire down = pmode != OMW_RUN;
    wire sys_osc_ok = clk_slow ? low_src_stable : fast_stable;

    // wake sources
    wire [NUM_PINS-1:0] pin_fall = pin_s3 & ~pin_s2 & wake_en;
    wire [NUM_IRQ-1:0] irq_wake = IRQ_FLAG_I & ~irq_mask;
    wire irq_any = |irq_wake;
    wire irq_serve = |(irq_wake & IRQ_ENABLE_I) && !CORE_I.stack_full;
    wire wake = |pin_fall || irq_any || CORE_I.watchdog_overflow;

    // halt decodes into the low-power mode
    omw_pmode_t halt_mode;
    assign halt_mode = !hold_fast && !hold_slow ? OMW_SLEEP :
                       !hold_fast ? OMW_IDLE_SLOW_ONLY :
                       hold_slow ? OMW_IDLE_BOTH_CLOCKS : OMW_IDLE_FAST_ONLY;

    // registers; one short flop group per software register, except wake enable and misc which share one
    wire [7:0] next_mode_ctrl = {wd[7:5], 2'b00, wd[2:0]};
    // speed-up changes are dropped while the slow crystal drives the core
    wire speedup_wr = wr_slow && !slow_xtal_is_sys;

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            mode_ctrl <= `OMW_MODE_CTRL_RST;
        else if (wr_mode)
            mode_ctrl <= next_mode_ctrl;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            fast_en <= 1'b0;
        else if (wr_fast)
            fast_en <= wd[`OMW_BIT_EN];
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            slow_en <= 1'b0;
            speedup <= 1'b0;
        end
        else
        begin
            if (wr_slow)
                slow_en <= wd[`OMW_BIT_EN];
            if (speedup_wr)
                speedup <= wd[`OMW_BIT_SPEEDUP];
        end
    end

    // watchdog enable resets on, so the RC runs from power-up
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            wake_en <= '0;
            wdt_en <= 1'b1;
        end
        else
        begin
            if (wr_wake)
                wake_en <= wd[NUM_PINS-1:0];
            if (wr_misc)
                wdt_en <= wd[`OMW_BIT_WDT_EN];
        end
    end

    // oscillator settling; a fresh enable restarts the count
    wire fast_restart = !FAST_OSC_EN_O || (wr_fast && wd[`OMW_BIT_EN] && !fast_en);
    wire slow_restart = !SLOW_OSC_EN_O || (wr_slow && wd[`OMW_BIT_EN] && !slow_en);

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            fast_cnt <= '0;
            fast_stable <= 1'b0;
        end
        else if (fast_restart)
        begin
            fast_cnt <= '0;
            fast_stable <= 1'b0;
        end
        else if (fast_cnt != fast_target)
            fast_cnt <= fast_cnt + 1'b1;
        else
            fast_stable <= 1'b1;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            slow_cnt <= '0;
            slow_stable <= 1'b0;
        end
        else if (slow_restart)
        begin
            slow_cnt <= '0;
            slow_stable <= 1'b0;
        end
        else if (slow_cnt < slow_target)
            slow_cnt <= slow_cnt + 1'b1;
        else
            slow_stable <= 1'b1;
    end

    // system clock source switching and fast divider enable
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            clk_slow <= 1'b0;
            div_cnt <= '0;
        end
        else
        begin
            if (want_slow && low_src_stable)
                clk_slow <= 1'b1;
            else if (!want_slow)
                clk_slow <= 1'b0;
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // divided-by-2^cks enable; slow clock is treated as undivided here
    wire [5:0] div_mask = 6'(({6'h00, 1'b1} << cks) - 7'h01);
    assign SYS_CLK_EN_O = cpu.run_cpu && (clk_slow || (div_cnt & div_mask) == 6'h00);

    // power-down sequencing: one named event per cause
    wire halt_go = !down && CORE_I.halt && cpu.run_cpu;
    wire wake_go = down && wake;
    wire wdt_wake = wake_go && CORE_I.watchdog_overflow;
    wire irq_take = wake_go && !CORE_I.watchdog_overflow && irq_serve;
    wire plain_resume = wake_go && !CORE_I.watchdog_overflow && !irq_serve;
    wire stable_done = wait_stable && sys_osc_ok;
    wire boot_run = !cpu.run_cpu && !down && !wait_stable;
    // run and wait_stable never overlap, so the run causes cannot collide
    wire next_run_cpu = halt_go ? 1'b0 : (boot_run || stable_done) ? 1'b1 : cpu.run_cpu;

    // two synchroniser flops plus an edge flop; idle high so reset makes no edge
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_s3 <= '1;
        end
        else
        begin
            pin_s1 <= PORT_A_I;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // halt wins over a watchdog clear in the same cycle
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            power_down_flag <= 1'b0;
            to_flag <= 1'b0;
        end
        else
        begin
            if (halt_go)
                power_down_flag <= 1'b1;
            else if (CORE_I.clear_watchdog)
                power_down_flag <= 1'b0;
            if (halt_go)
                to_flag <= 1'b0;
            else if (wdt_wake)
                to_flag <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            irq_mask <= '0;
        else if (halt_go)
            irq_mask <= IRQ_FLAG_I;
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pmode <= OMW_RUN;
            wait_stable <= 1'b0;
        end
        else
        begin
            if (halt_go)
                pmode <= halt_mode;
            else if (wake_go)
                pmode <= OMW_RUN;
            if (stable_done)
                wait_stable <= 1'b0;
            else if (wake_go)
                wait_stable <= 1'b1;
        end
    end

    // core controls; the action pulses last one cycle
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            cpu <= '0;
        else
        begin
            cpu.run_cpu <= next_run_cpu;
            cpu.resume_after_halt <= plain_resume;
            cpu.take_interrupt <= irq_take;
            cpu.reset_pc_sp <= wdt_wake;
            cpu.clear_watchdog_count <= halt_go;
        end
    end

    // clock gating per mode
    assign FAST_CLK_RUN_O = pmode == OMW_RUN || pmode == OMW_IDLE_BOTH_CLOCKS
                         || pmode == OMW_IDLE_FAST_ONLY;
    assign LOW_CLK_RUN_O = pmode == OMW_RUN || pmode == OMW_IDLE_SLOW_ONLY
                         || pmode == OMW_IDLE_BOTH_CLOCKS;
    assign FAST_OSC_EN_O = (fast_en || !clk_slow || wait_stable) && (FAST_CLK_RUN_O || wait_stable);
    assign SLOW_OSC_EN_O = slow_en && (LOW_CLK_RUN_O || wait_stable);
    assign SLOW_OSC_SPEEDUP_O = speedup;
    assign LOW_RC_EN_O = wdt_en || (!low_clock_source_select && LOW_CLK_RUN_O);
    assign SYS_CLK_SLOW_O = clk_slow;
    assign POWER_MODE_O = pmode;
    assign CPU_O = cpu;

    // Avalon-MM: writes take one cycle, reads wait one cycle for registered data
    always_comb
    begin
        rdata = 32'h0000_0000;
        case (AVS_ADDRESS_I)
            `OMW_OFF_MODE_CTRL: rdata[7:0] = mode_ctrl;
            `OMW_OFF_FAST_CTRL: rdata[1:0] = {fast_stable, fast_en};
            `OMW_OFF_SLOW_CTRL: rdata[2:0] = {speedup, slow_stable, slow_en};
            `OMW_OFF_WAKE_EN: rdata[NUM_PINS-1:0] = wake_en;
            `OMW_OFF_STATUS: rdata[2:0] = {clk_slow, to_flag, power_down_flag};
            `OMW_OFF_MISC: rdata[0] = wdt_en;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rd_pend <= 1'b0;
            AVS_READDATA_O <= 32'h0000_0000;
            AVS_RESPONSE_O <= 2'h0;
        end
        else
        begin
            rd_pend <= AVS_READ_I && !rd_pend;
            if (AVS_READ_I && !rd_pend)
            begin
                AVS_READDATA_O <= rdata;
                AVS_RESPONSE_O <= mapped ? 2'h0 : 2'h2;
            end
        end
    end

    assign AVS_WAITREQUEST_O = AVS_READ_I && !rd_pend;
endmodule : omw_top

// ===== src/omw_defines.svh
// offsets, field positions, reset values and timing counts for the oscillator/wake block
`ifndef OMW_DEFINES_SVH
`define OMW_DEFINES_SVH
`define OMW_OFF_MODE_CTRL 4'h0
`define OMW_OFF_FAST_CTRL 4'h1
`define OMW_OFF_SLOW_CTRL 4'h2
`define OMW_OFF_WAKE_EN 4'h3
`define OMW_OFF_STATUS 4'h4
`define OMW_OFF_MISC 4'h5
`define OMW_MODE_CTRL_RST 8'h40
`define OMW_BIT_EN 0
`define OMW_BIT_STABLE 1
`define OMW_BIT_SPEEDUP 2
`define OMW_BIT_SLOW_OSC_HOLD_IN_HALT 0
`define OMW_BIT_FAST_OSC_HOLD_IN_HALT 1
`define OMW_BIT_FSS 2
`define OMW_CKS_LSB 5
`define OMW_CKS_SLOW 3'h7
`define OMW_BIT_PDF 0
`define OMW_BIT_TO 1
`define OMW_BIT_WDT_EN 0
`define OMW_FAST_SETTLE_NS 2000
`define OMW_SLOW_FAST_NS 20000
`define OMW_SLOW_LOWP_NS 80000
`define OMW_CLK_NS 4
`define OMW_FAST_SETTLE_CYC ((`OMW_FAST_SETTLE_NS + `OMW_CLK_NS - 1) / `OMW_CLK_NS)
`define OMW_SLOW_FAST_CYC ((`OMW_SLOW_FAST_NS + `OMW_CLK_NS - 1) / `OMW_CLK_NS)
`define OMW_SLOW_LOWP_CYC ((`OMW_SLOW_LOWP_NS + `OMW_CLK_NS - 1) / `OMW_CLK_NS)
`endif

// ===== src/omw_pkg.sv
// types for the oscillator mode and wake-up control block
package omw_pkg;
    typedef enum logic [2:0] {
        OMW_RUN, OMW_SLEEP, OMW_IDLE_SLOW_ONLY, OMW_IDLE_BOTH_CLOCKS, OMW_IDLE_FAST_ONLY
    } omw_pmode_t;
    typedef struct packed {
        logic halt;
        logic clear_watchdog;
        logic watchdog_overflow;
        logic stack_full;
    } omw_core_t;
    typedef struct packed {
        logic run_cpu;
        logic resume_after_halt;
        logic take_interrupt;
        logic reset_pc_sp;
        logic clear_watchdog_count;
    } omw_cpu_t;
endpackage : omw_pkg

// ===== sim/omw_checker.sv
// port assertions for the oscillator mode and wake-up block
`timescale 1ns/10ps
module omw_checker
    import omw_pkg::*;
(
    input logic CLK_I,
    input logic RST_B_I,
    input omw_core_t CORE_I,
    input omw_cpu_t CPU_O,
    input omw_pmode_t POWER_MODE_O,
    input logic FAST_CLK_RUN_O,
    input logic LOW_CLK_RUN_O,
    input logic SYS_CLK_EN_O,
    input logic SYS_CLK_SLOW_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    wire up = POWER_MODE_O == OMW_RUN;
    wire go_down = CORE_I.halt && up;
    wire any_wake = CPU_O.resume_after_halt || CPU_O.take_interrupt || CPU_O.reset_pc_sp;
    halt_mode_a: assert property (go_down |=> !up && !CPU_O.run_cpu)
        else $error("halt left the core running");
    halt_wdclr_a: assert property (go_down |=> CPU_O.clear_watchdog_count)
        else $error("halt did not clear the watchdog count");
    sleep_stop_a: assert property (POWER_MODE_O == OMW_SLEEP |-> !FAST_CLK_RUN_O && !SYS_CLK_EN_O)
        else $error("clock running in sleep");
    idle_slow_a: assert property (POWER_MODE_O == OMW_IDLE_SLOW_ONLY |-> !FAST_CLK_RUN_O && LOW_CLK_RUN_O)
        else $error("wrong clocks in slow-only idle");
    idle_both_a: assert property (POWER_MODE_O == OMW_IDLE_BOTH_CLOCKS |-> FAST_CLK_RUN_O && LOW_CLK_RUN_O)
        else $error("wrong clocks in both-clock idle");
    idle_fast_a: assert property (POWER_MODE_O == OMW_IDLE_FAST_ONLY |-> FAST_CLK_RUN_O && !LOW_CLK_RUN_O)
        else $error("wrong clocks in fast-only idle");
    down_cpu_a: assert property (!up |-> !CPU_O.run_cpu)
        else $error("core runs while powered down");
    wake_kind_a: assert property (!up ##1 up |-> any_wake)
        else $error("wake-up without a resume action");
    wdt_wake_a: assert property (!up && CORE_I.watchdog_overflow |=> CPU_O.reset_pc_sp && !CPU_O.resume_after_halt)
        else $error("watchdog wake did not reset pc and sp");
    run_late_a: assert property ($rose(CPU_O.run_cpu) |-> $past(up))
        else $error("core restarted in the wake cycle");
    slow_every_a: assert property (SYS_CLK_SLOW_O && up && CPU_O.run_cpu |-> SYS_CLK_EN_O)
        else $error("slow mode skipped a core clock");
    cover property (go_down);
    cover property (!up ##1 up);
    cover property (SYS_CLK_SLOW_O && up);
endmodule : omw_checker
bind omw_top omw_checker chk (.CLK_I, .RST_B_I, .CORE_I, .CPU_O, .POWER_MODE_O, .FAST_CLK_RUN_O,
    .LOW_CLK_RUN_O, .SYS_CLK_EN_O, .SYS_CLK_SLOW_O);

// ===== sim/omw_core_model.sv
// core, wake pins and watchdog stand-in on the block's far side
`timescale 1ns/10ps
module omw_core_model
    import omw_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire omw_cpu_t cpu_i,
    input wire logic [2:0] cmd_i,
    input wire logic full_i,
    input wire logic [7:0] pin_low_i,
    output omw_core_t core_o,
    output logic [7:0] pins_o
);
    // pins rest high on their pull-ups
    assign pins_o = ~pin_low_i;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            core_o <= '0;
        else
            // a stopped core executes no instruction
            core_o <= '{cmd_i[0] & cpu_i.run_cpu, cmd_i[1] & cpu_i.run_cpu, cmd_i[2], full_i};
    end
endmodule : omw_core_model

// ===== sim/tb_top.sv
// self-checking bench for the oscillator mode and wake-up block
`timescale 1ns/10ps
module tb_top;
    import omw_pkg::*;
    logic clk = 0;
    logic rst_b = 1;
    logic fast_osc_en, slow_osc_en, speedup_o, low_rc_en, fast_run, low_run;
    logic rd_q = 0;
    logic wr_q = 0;
    logic full = 0;
    logic [2:0] cmd = 3'h0;
    logic [3:0] ad = 4'h0;
    logic [7:0] wd = 8'h00;
    logic [7:0] irq = 8'h00;
    logic [7:0] ien = 8'h00;
    logic [7:0] pin_low = 8'h00;
    logic [7:0] pins;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [1:0] resp;
    logic [1:0] rs;
    logic wait_q;
    logic sys_en;
    logic sys_slow;
    omw_core_t core;
    omw_cpu_t cpu;
    omw_pmode_t pm;
    int fails = 0;
    int n_checks = 0;
    int n;
    int cnt [3] = '{0, 0, 0};
    omw_pmode_t tbl [4] = '{OMW_SLEEP, OMW_IDLE_SLOW_ONLY, OMW_IDLE_FAST_ONLY, OMW_IDLE_BOTH_CLOCKS};
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cnt[0] += int'(cpu.resume_after_halt === 1'b1);
        cnt[1] += int'(cpu.take_interrupt === 1'b1);
        cnt[2] += int'(cpu.reset_pc_sp === 1'b1);
    end
    // short settling counts keep the run brief
    omw_top #(.FAST_SETTLE_CYC(20), .SLOW_FAST_CYC(24), .SLOW_LOWP_CYC(48)) uut (
        .CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(ad), .AVS_READ_I(rd_q), .AVS_WRITE_I(wr_q),
        .AVS_WRITEDATA_I({24'h000000, wd}), .AVS_BYTEENABLE_I(4'h1), .AVS_READDATA_O(rdat),
        .AVS_WAITREQUEST_O(wait_q), .AVS_RESPONSE_O(resp), .CORE_I(core), .IRQ_FLAG_I(irq),
        .IRQ_ENABLE_I(ien), .PORT_A_I(pins), .CPU_O(cpu), .FAST_OSC_EN_O(fast_osc_en),
        .SLOW_OSC_EN_O(slow_osc_en), .SLOW_OSC_SPEEDUP_O(speedup_o), .LOW_RC_EN_O(low_rc_en),
        .SYS_CLK_SLOW_O(sys_slow), .SYS_CLK_EN_O(sys_en), .FAST_CLK_RUN_O(fast_run),
        .LOW_CLK_RUN_O(low_run), .POWER_MODE_O(pm));
    omw_core_model cm (.clk_i(clk), .rst_b_i(rst_b), .cpu_i(cpu), .cmd_i(cmd), .full_i(full),
        .pin_low_i(pin_low), .core_o(core), .pins_o(pins));
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask : chk
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr_q <= w;
        rd_q <= !w;
        do
            @(posedge clk);
        while (wait_q !== 1'b0);
        q = rdat;
        rs = resp;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask : bus
    task rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %0d", a), q, {24'h000000, e});
    endtask : rd
    task pulse(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask : pulse
    task nap(input omw_pmode_t m);
        n = 0;
        while (cpu.run_cpu !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        pulse(3'h1);
        repeat (3) @(posedge clk);
        chk("mode", pm, m);
    endtask : nap
    task wake(input int k);
        int c;
        c = cnt[k];
        repeat (40) @(posedge clk);
        chk("wake count", cnt[k] - c, 1);
        chk("run", cpu.run_cpu, 1);
        pin_low <= 8'h00;
    endtask : wake
    task conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        #200000;
        fails++;
        conclude();
    end
    initial
    begin
        // a real falling edge, so the asynchronous reset branches run
        rst_b <= 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h00);
        bus(1'b0, 4'h9, 8'h00);
        chk("unmapped response", rs, 2'b10);
        bus(1'b1, 4'h2, 8'h01);
        repeat (30) @(posedge clk);
        rd(4'h2, 8'h01);
        repeat (25) @(posedge clk);
        rd(4'h2, 8'h03);
        bus(1'b1, 4'h2, 8'h00);
        bus(1'b1, 4'h2, 8'h05);
        repeat (30) @(posedge clk);
        rd(4'h2, 8'h07);
        chk("speed-up pin", speedup_o, 1);
        chk("slow osc enable", slow_osc_en, 1);
        bus(1'b1, 4'h0, 8'hE4);
        repeat (4) @(posedge clk);
        chk("slow clock", sys_slow, 1);
        chk("fast osc off", fast_osc_en, 0);
        rd(4'h4, 8'h04);
        bus(1'b1, 4'h2, 8'h01);
        rd(4'h2, 8'h07);
        bus(1'b1, 4'h1, 8'h00);
        bus(1'b1, 4'h1, 8'h01);
        rd(4'h1, 8'h01);
        chk("fast osc on", fast_osc_en, 1);
        n = 0;
        do
        begin
            bus(1'b0, 4'h1, 8'h00);
            n++;
        end
        while (q[1] !== 1'b1 && n < 40);
        chk("fast stable", q, 32'h3);
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b1, 4'h0, 8'(k << 5));
            n = 0;
            repeat (128)
            begin
                @(posedge clk);
                n += int'(sys_en === 1'b1);
            end
            chk("clock enables", n, 128 >> k);
        end
        bus(1'b1, 4'h0, 8'hE0);
        repeat (2) @(posedge clk);
        chk("slow clock on rc", sys_slow, 1);
        chk("rc enable", low_rc_en, 1);
        bus(1'b1, 4'h3, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, 4'h0, 8'(m));
            nap(tbl[m]);
            chk("fast run", fast_run, 32'(m / 2));
            chk("low run", low_run, 32'(m % 2));
            chk("rc on", low_rc_en, 1);
            rd(4'h4, 8'h01);
            pin_low <= 8'h01;
            wake(0);
        end
        rd(4'h4, 8'h01);
        pulse(3'h2);
        rd(4'h4, 8'h00);
        bus(1'b1, 4'h0, 8'h00);
        bus(1'b1, 4'h5, 8'h00);
        nap(OMW_SLEEP);
        chk("rc off", low_rc_en, 0);
        pulse(3'h4);
        wake(2);
        rd(4'h4, 8'h03);
        irq <= 8'h02;
        ien <= 8'h02;
        nap(OMW_SLEEP);
        repeat (20) @(posedge clk);
        chk("mode", pm, OMW_SLEEP);
        pin_low <= 8'h01;
        wake(0);
        nap(OMW_SLEEP);
        irq <= 8'h06;
        wake(0);
        full <= 1'b1;
        nap(OMW_SLEEP);
        irq <= 8'h0E;
        ien <= 8'h0E;
        wake(0);
        full <= 1'b0;
        nap(OMW_SLEEP);
        irq <= 8'h1E;
        ien <= 8'h1E;
        wake(1);
        conclude();
    end
endmodule : tb_top
